// *** core/smbm_engine.sv ***
// Purpose: Master engine of a two-wire bus controller with an APB register port.
// Assumes: Open-drain lines resolved outside; line inputs asynchronous.
// Notes:   Clearing the enable bit resets all but control register 2, the address registers, the line synchroniser and the APB port.
// How it works
// RL1 - Start request issues Start once bus free, then holds clock low.
// RL2 - Clock pulled low by another during start sets bus error.
// RL3 - Clean start sets master flag and data buffer ready flag.
// RL4 - Interrupt when enabled and bus error or buffer ready after start.
// RL5 - Firmware avoids own, general call and ARP addresses when they match.
// RL6 - Firmware sets ack control or stall-after-start before address write.
// RL7 - Writing address byte launches transfer; acknowledge goes to NACK flag.
// RL8 - Conflict during address aborts, sets bus error, clears master.
// RL9 - Stall-after-start on clean address sets its flag, holds clock.
// RL10 - Clean transmit address sets data buffer ready flag.
// RL11 - Clean receive address without stall starts first byte automatically.
// RL12 - Interrupt when enabled on bus error or NACK.
// RL13 - Firmware checks flags, clears stall flag, then writes data byte.
// RL14 - NACK on transmitted byte sets NACK flag, buffer ready stays clear.
// RL15 - Ack control set before next-to-last read makes last byte NACKed.
// RL16 - Stop request while master sends Stop now and self-clears.
// RL17 - Master stalls clock after acknowledge while any stall flag set.
// RL18 - Repeated start: set start, read byte, write address, clear stall.
// RL19 - Start or Stop inside a bit, or data conflict, is bus error.
// RL20 - Deadlock recovery clears error and busy, waits, then toggles enable.
// RL21 - Disable then enable fully resets to unaddressed slave.
// RL22 - Firmware resynchronises slaves with start, one address, stop.
// RL23 - Data read while start requested keeps buffer ready flag set.
// RL24 - Bus error and NACK flags clear on write of one or disable.
// RL25 - Status reads zero after reset and while disabled.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`default_nettype none
module smbm_engine #(
  parameter int unsigned AW = 12
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [AW-1:0] i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  output logic               o_scl_o,
  output logic               o_scl_oe,
  output logic               o_sda_o,
  output logic               o_sda_oe,
  output logic               o_irq
);
  smbm_pkg::smbm_state_e st_q, st_d;
  logic [7:0] ctl1_q, ctl2_q, addr1_q, addr2_q, shift_q;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] bitn_q, bitn_d;
  logic       dbr_q, ber_q, nack_q, stasr_q, master_q, xmit_q, busy_q;
  logic       addr_ph_q, sda_p_q, scl_oe_d, sda_oe_d;
  logic       ev_ber, ev_start, ev_stop, ev_bit, ev_byte;
  logic [1:0] lines_s;

  // Line inputs pass two flops first.
  smbm_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_scl, i_sda}),
    .o_sync  (lines_s)
  );

  // Register index decode.
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction

  // Bus slave strobes; every access takes one wait state.
  wire logic [7:0] idx      = i_paddr[9:2];
  wire logic       acc      = i_psel & i_penable & o_pready;
  wire logic       wr       = acc & i_pwrite;
  wire logic       rd       = acc & ~i_pwrite;
  wire logic       wr_sda   = wr & hit(idx, smbm_pkg::IDX_SDA);
  wire logic       wr_st    = wr & hit(idx, smbm_pkg::IDX_ST);
  wire logic       wr_cst   = wr & hit(idx, smbm_pkg::IDX_CST);
  wire logic       wr_ctl1  = wr & hit(idx, smbm_pkg::IDX_CTL1);
  wire logic       rd_sda   = rd & hit(idx, smbm_pkg::IDX_SDA);
  wire logic       mapped   = ~idx[0] & (idx <= smbm_pkg::IDX_ADDR2);

  // Soft reset while the module is disabled. [RL21]
  wire logic       srst     = ~ctl2_q[smbm_pkg::C2_EN];
  wire logic       scl_s    = lines_s[1];
  wire logic       sda_s    = lines_s[0];
  wire logic       start_q  = ctl1_q[smbm_pkg::C1_START];
  wire logic       stop_q   = ctl1_q[smbm_pkg::C1_STOP];
  wire logic       stase    = ctl1_q[smbm_pkg::C1_STASE];
  wire logic       ack_ctl  = ctl1_q[smbm_pkg::C1_ACK];
  wire logic [7:0] half     = {1'b0, ctl2_q[7:1]};
  wire logic       tdone    = (cnt_q == 8'h00);
  wire logic       sending  = xmit_q | addr_ph_q;
  wire logic       is_ack   = (bitn_q == smbm_pkg::BIT_ACK);

  // Bus conditions seen on the synchronised lines.
  wire logic       start_det = scl_s & sda_p_q & ~sda_s;
  wire logic       stop_det  = scl_s & ~sda_p_q & sda_s;
  wire logic       bus_free  = ~busy_q & scl_s & sda_s;
  wire logic       tx_bit    = sending & ~is_ack;
  // Released data read low while sending: another master won. [RL8] [RL19]
  wire logic       bit_err   = scl_s & (start_det | stop_det | (tx_bit & ~o_sda_oe & ~sda_s));
  // Receiver NACKs while ack control is set. [RL15]
  wire logic       sda_want  = is_ack ? (~sending & ~ack_ctl) : (sending & ~shift_q[7]);
  // Apart from a stop request, the engine leaves a stall only once no stall flag is pending. [RL17] [RL13]
  wire logic       go        = ~(dbr_q | nack_q | stasr_q);

  // Byte completion outcomes.
  wire logic       nack_ev   = ev_byte & sending & sda_s;
  wire logic       stasr_ev  = ev_byte & addr_ph_q & ~sda_s & stase;
  wire logic       dbr_ev    = (ev_start & ~master_q)
                             | (ev_byte & ~nack_ev & (~addr_ph_q | (~stase & xmit_q)));

  // Status view; all fields clear while disabled. [RL25]
  wire logic [7:0] st_view   = {1'b0, dbr_q, ber_q, nack_q, stasr_q, 1'b0, master_q, xmit_q};
  wire logic [7:0] rd_val    = hit(idx, smbm_pkg::IDX_SDA)   ? shift_q :
                               hit(idx, smbm_pkg::IDX_ST)    ? st_view :
                               hit(idx, smbm_pkg::IDX_CST)   ? {7'h00, busy_q} :
                               hit(idx, smbm_pkg::IDX_CTL1)  ? ctl1_q :
                               hit(idx, smbm_pkg::IDX_ADDR1) ? addr1_q :
                               hit(idx, smbm_pkg::IDX_CTL2)  ? ctl2_q :
                               hit(idx, smbm_pkg::IDX_ADDR2) ? addr2_q : 8'h00;

  // Open-drain lines only ever pull low.
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;

  // Engine next state.
  always_comb begin
    st_d     = st_q;
    cnt_d    = tdone ? cnt_q : cnt_q - 8'h01;
    bitn_d   = bitn_q;
    scl_oe_d = o_scl_oe;
    sda_oe_d = o_sda_oe;
    ev_ber   = 1'b0;
    ev_start = 1'b0;
    ev_stop  = 1'b0;
    ev_bit   = 1'b0;
    ev_byte  = 1'b0;
    unique case (st_q)
      smbm_pkg::S_IDLE: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        cnt_d    = half;
        if (start_q && bus_free) begin
          st_d = smbm_pkg::S_STA; // [RL1]
        end
      end
      smbm_pkg::S_STA: begin
        sda_oe_d = 1'b1;
        if (!scl_s) begin
          ev_ber = 1'b1; // [RL2]
        end else if (tdone) begin
          scl_oe_d = 1'b1; // [RL1]
          ev_start = 1'b1;
          cnt_d    = half;
          bitn_d   = 4'h0;
          st_d     = master_q ? smbm_pkg::S_LOW : smbm_pkg::S_STALL;
        end
      end
      smbm_pkg::S_STALL: begin
        scl_oe_d = 1'b1; // [RL17]
        cnt_d    = half;
        bitn_d   = 4'h0;
        if (stop_q) begin
          st_d = smbm_pkg::S_STL; // [RL16]
        end else if (go) begin
          st_d = start_q ? smbm_pkg::S_RSL : smbm_pkg::S_LOW; // [RL18] [RL11]
        end
      end
      smbm_pkg::S_LOW: begin
        if (cnt_q == {1'b0, half[7:1]}) begin
          sda_oe_d = sda_want;
        end
        if (tdone) begin
          scl_oe_d = 1'b0;
          cnt_d    = half;
          st_d     = smbm_pkg::S_HIGH;
        end
      end
      smbm_pkg::S_HIGH: begin
        if (!scl_s) begin
          cnt_d = half;
        end
        if (bit_err) begin
          ev_ber = 1'b1; // [RL8] [RL19]
        end else if (scl_s && tdone) begin
          scl_oe_d = 1'b1;
          cnt_d    = half;
          ev_bit   = 1'b1;
          if (is_ack) begin
            ev_byte = 1'b1; // [RL7]
            st_d    = smbm_pkg::S_STALL;
          end else begin
            bitn_d = bitn_q + 4'h1;
            st_d   = smbm_pkg::S_LOW;
          end
        end
      end
      smbm_pkg::S_RSL: begin
        sda_oe_d = 1'b0;
        if (tdone) begin
          scl_oe_d = 1'b0;
          cnt_d    = half;
          st_d     = smbm_pkg::S_RSH;
        end
      end
      smbm_pkg::S_RSH: begin
        if (!scl_s) begin
          cnt_d = half;
        end else if (tdone) begin
          cnt_d = half;
          st_d  = smbm_pkg::S_STA;
        end
      end
      smbm_pkg::S_STL: begin
        sda_oe_d = 1'b1;
        if (tdone) begin
          scl_oe_d = 1'b0;
          cnt_d    = half;
          st_d     = smbm_pkg::S_STH;
        end
      end
      smbm_pkg::S_STH: begin
        if (!scl_s) begin
          cnt_d = half;
        end else if (tdone) begin
          sda_oe_d = 1'b0; // [RL16]
          ev_stop  = 1'b1;
          st_d     = smbm_pkg::S_IDLE;
        end
      end
      default: begin
        st_d = smbm_pkg::S_IDLE;
      end
    endcase
    // An error drops both lines and leaves master mode.
    if (ev_ber) begin
      st_d     = smbm_pkg::S_IDLE;
      scl_oe_d = 1'b0;
      sda_oe_d = 1'b0;
    end
  end

  // Engine state and line drivers.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || srst) begin
      st_q     <= smbm_pkg::S_IDLE;
      cnt_q    <= 8'h00;
      bitn_q   <= 4'h0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      sda_p_q  <= 1'b1;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      bitn_q   <= bitn_d;
      o_scl_oe <= scl_oe_d;
      o_sda_oe <= sda_oe_d;
      sda_p_q  <= sda_s;
    end
  end

  // Shift register; a firmware write launches the next byte. [RL7]
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || srst) begin
      shift_q <= 8'h00;
    end else if (wr_sda) begin
      shift_q <= i_pwdata[7:0];
    end else if (ev_bit && !is_ack) begin
      shift_q <= {shift_q[6:0], sda_s};
    end
  end

  // Status flags; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || srst) begin
      {dbr_q, ber_q, nack_q, stasr_q} <= 4'h0; // [RL24] [RL25]
      {master_q, xmit_q, addr_ph_q}   <= 3'h0;
      busy_q                          <= 1'b0;
    end else begin
      ber_q   <= ev_ber | (ber_q & ~(wr_st & i_pwdata[smbm_pkg::ST_BER])); // [RL24] [RL8]
      nack_q  <= nack_ev | (nack_q & ~(wr_st & i_pwdata[smbm_pkg::ST_NACK])); // [RL14] [RL24]
      stasr_q <= stasr_ev | (stasr_q & ~(wr_st & i_pwdata[smbm_pkg::ST_STASR])); // [RL9]
      // A data read with start pending keeps the flag. [RL23]
      dbr_q   <= dbr_ev | (dbr_q & ~wr_sda & ~(rd_sda & ~start_q)); // [RL3] [RL10]
      if (ev_ber || ev_stop) begin
        master_q <= 1'b0; // [RL8] [RL19]
      end else if (ev_start) begin
        master_q <= 1'b1; // [RL3]
      end
      if (ev_ber || ev_stop) begin
        xmit_q <= 1'b0;
      end else if (wr_sda && (addr_ph_q || start_q)) begin
        xmit_q <= ~i_pwdata[0];
      end
      if (ev_ber || ev_byte) begin
        addr_ph_q <= 1'b0;
      end else if ((ev_start && !master_q) || (wr_sda && start_q)) begin
        addr_ph_q <= 1'b1;
      end
      // Busy follows bus conditions; firmware may clear it for recovery. [RL20]
      busy_q <= start_det | (busy_q & ~stop_det & ~(wr_cst & i_pwdata[smbm_pkg::CST_BUSY]));
    end
  end

  // Control registers; stop writes are ignored unless we hold the bus.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctl2_q  <= smbm_pkg::CTL2_RST;
      addr1_q <= smbm_pkg::ADDR_RST;
      addr2_q <= smbm_pkg::ADDR_RST;
    end else if (wr) begin
      if (hit(idx, smbm_pkg::IDX_CTL2)) ctl2_q <= i_pwdata[7:0];
      if (hit(idx, smbm_pkg::IDX_ADDR1)) addr1_q <= i_pwdata[7:0];
      if (hit(idx, smbm_pkg::IDX_ADDR2)) addr2_q <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || srst) begin
      ctl1_q <= smbm_pkg::CTL1_RST;
    end else begin
      if (wr_ctl1) begin
        ctl1_q                    <= i_pwdata[7:0];
        ctl1_q[smbm_pkg::C1_STOP] <= i_pwdata[smbm_pkg::C1_STOP] & master_q;
      end
      if (ev_start || ev_ber) begin
        ctl1_q[smbm_pkg::C1_START] <= 1'b0;
      end
      if (ev_stop) begin
        ctl1_q[smbm_pkg::C1_STOP] <= 1'b0; // [RL16]
      end
    end
  end

  // Interrupt is a level of the enabled stall and error flags. [RL4] [RL9] [RL12] [RL14]
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ctl1_q[smbm_pkg::C1_IRQ] & (ber_q | nack_q | dbr_q | stasr_q);
    end
  end

  // APB answer after one wait state.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
      if (i_psel && i_penable && !o_pready) begin
        o_prdata <= {24'h00_0000, rd_val};
      end
    end
  end
endmodule
`default_nettype wire

// *** core/smbm_sync.sv ***
// Purpose: Two-flop synchroniser for the bus line inputs.
// Assumes: Inputs are asynchronous to i_clock.
// Notes:   Lines idle high, so the flops reset to ones.
`default_nettype none
module smbm_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // Only the second flop is read outside this module.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_q <= '1;
      o_sync <= '1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** shared/smbm_pkg.sv ***
// Purpose: Shared constants and types for the two-wire bus master engine.
// Assumes: 25 MHz core clock; registers reached by word index over APB.
// Notes:   Byte address of a register is four times its index.
`default_nettype none
package smbm_pkg;
  // Core clock and the least half period of the bus clock.
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned T_HALF_NS = 5000;
  localparam int unsigned HALF_CYC  = (T_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Register indices.
  localparam logic [7:0] IDX_SDA   = 8'h00;
  localparam logic [7:0] IDX_ST    = 8'h02;
  localparam logic [7:0] IDX_CST   = 8'h04;
  localparam logic [7:0] IDX_CTL1  = 8'h06;
  localparam logic [7:0] IDX_ADDR1 = 8'h08;
  localparam logic [7:0] IDX_CTL2  = 8'h0A;
  localparam logic [7:0] IDX_ADDR2 = 8'h0C;

  // Status register fields.
  localparam int unsigned ST_DBR    = 6;
  localparam int unsigned ST_BER    = 5;
  localparam int unsigned ST_NACK   = 4;
  localparam int unsigned ST_STASR  = 3;
  localparam int unsigned ST_MASTER = 1;
  localparam int unsigned ST_XMIT   = 0;

  // Control register 1 fields.
  localparam int unsigned C1_START = 0;
  localparam int unsigned C1_STOP  = 1;
  localparam int unsigned C1_IRQ   = 2;
  localparam int unsigned C1_ACK   = 3;
  localparam int unsigned C1_STASE = 7;

  // Control status and control register 2 fields.
  localparam int unsigned CST_BUSY = 0;
  localparam int unsigned C2_EN    = 0;

  // Reset values.
  localparam logic [7:0] ST_RST   = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = {HALF_CYC[6:0], 1'b0};

  // Bit index of the acknowledge slot within a byte.
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Engine states.
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_STA   = 9'h002,
    S_STALL = 9'h004,
    S_LOW   = 9'h008,
    S_HIGH  = 9'h010,
    S_RSL   = 9'h020,
    S_RSH   = 9'h040,
    S_STL   = 9'h080,
    S_STH   = 9'h100
  } smbm_state_e;
endpackage
`default_nettype wire

// *** tb/smbm_engine_bench.sv ***
// Purpose: Self-checking bench for the two-wire bus master engine.
// Assumes: Bus half period is set to four core cycles, a 320 ns bus clock.
// Notes:   Sent bytes wait in a queue and are compared with what the slave took.
`default_nettype none
module smbm_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLV = 7'h2A;
  localparam logic [7:0] R_SDA = smbm_pkg::IDX_SDA, R_ST = smbm_pkg::IDX_ST, R_CST = smbm_pkg::IDX_CST;
  localparam logic [7:0] R_C1 = smbm_pkg::IDX_CTL1, R_C2 = smbm_pkg::IDX_CTL2;
  localparam logic [7:0] K_STA = 8'h01 << smbm_pkg::C1_START, K_STO = 8'h01 << smbm_pkg::C1_STOP;
  localparam logic [7:0] K_IRQ = 8'h01 << smbm_pkg::C1_IRQ, K_ACK = 8'h01 << smbm_pkg::C1_ACK;
  localparam logic [7:0] K_SAS = 8'h01 << smbm_pkg::C1_STASE, F_DBR = 8'h01 << smbm_pkg::ST_DBR;
  localparam logic [7:0] F_BER = 8'h01 << smbm_pkg::ST_BER, F_NAK = 8'h01 << smbm_pkg::ST_NACK;
  localparam logic [7:0] F_SAS = 8'h01 << smbm_pkg::ST_STASR, F_MST = 8'h01 << smbm_pkg::ST_MASTER;
  localparam logic [7:0] F_ALL = F_DBR | F_BER | F_NAK | F_SAS | F_MST;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic        scl, sda, scl_oe, sda_oe, slv_scl, slv_sda, frc_sda, nack, stretch;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rd, b, tx, rx;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          seed;
  // Open-drain wires with pull-ups.
  assign scl = !(scl_oe || slv_scl);
  assign sda = !(sda_oe || slv_sda || frc_sda);
  always #20 clk = !clk;
  smbm_engine #(.AW(12)) dut_u (
    .i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_scl(scl), .i_sda(sda), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(), .o_sda_oe(sda_oe), .o_irq(irq));
  smbm_slave_model #(.ADDR(SLV)) slv_u (.i_scl(scl), .i_sda(sda), .i_nack(nack), .i_stretch(stretch),
    .i_tx(tx), .o_sda_pull(slv_sda), .o_scl_pull(slv_scl), .o_rx(rx));
  // Counts every comparison; prints each mismatch.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded poll; the caller compares afterwards.
  task automatic wait_reg(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] val);
    int n = 0;
    do begin
      apb(1'b0, idx, 8'h00);
      n++;
    end while ((rd & mask) !== val && n < 500);
  endtask
  task automatic start(input logic [7:0] c1);
    apb(1'b1, R_C1, c1 | K_STA);
    wait_reg(R_ST, F_ALL, F_MST | F_DBR);
    chk("start_status", rd & F_ALL, F_MST | F_DBR);
  endtask
  // Stop comes before the stall flag is cleared; a zero mask reads the byte.
  task automatic stop(input logic [7:0] clr);
    apb(1'b1, R_C1, K_STO);
    if (clr == 8'h00) begin
      apb(1'b0, R_SDA, 8'h00);
      chk("rx_data", rd, tx);
    end else begin
      apb(1'b1, R_ST, clr);
    end
    wait_reg(R_C1, K_STO, 8'h00);
    chk("stop_self_clear", rd & K_STO, 8'h00);
    wait_reg(R_ST, F_ALL, 8'h00);
    chk("stop_status", rd & F_ALL, 8'h00);
  endtask
  task automatic addr_case(input logic sas);
    start(sas ? K_SAS | K_IRQ : 8'h00);
    apb(1'b1, R_SDA, {sas ? SLV : 7'h11, 1'b0});
    wait_reg(R_ST, F_NAK | F_SAS, sas ? F_SAS : F_NAK);
    chk("addr_end", rd & F_ALL, F_MST | (sas ? F_SAS : F_NAK));
    chk("addr_irq", {7'h00, irq}, {7'h00, sas});
    stop(sas ? F_SAS : F_NAK);
  endtask
  task automatic close_out;
    $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Far beyond what the whole run needs.
  initial begin
    #2000000;
    n_mismatch++;
    close_out;
  end
  initial begin
    seed = 32'h5C2C;
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    frc_sda = 1'b0;
    nack = 1'b0;
    stretch = 1'b0;
    tx = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, R_ST, 8'h00);
    chk("status_reset", rd, smbm_pkg::ST_RST);
    apb(1'b0, R_C1, 8'h00);
    chk("ctl1_reset", rd, smbm_pkg::CTL1_RST);
    apb(1'b0, 8'h0E, 8'h00);
    chk("unmapped_err", {7'h00, last_err}, 8'h01);
    apb(1'b1, R_C2, 8'h09);
    start(K_IRQ);
    chk("irq_start", {7'h00, irq}, 8'h01);
    apb(1'b1, R_SDA, {SLV, 1'b0});
    wait_reg(R_ST, F_ALL, F_MST | F_DBR);
    chk("tx_addr", rd & F_ALL, F_MST | F_DBR);
    repeat (4) begin
      b = 8'($random(seed));
      stretch <= b[0];
      exp_q.push_back(b);
      apb(1'b1, R_SDA, b);
      wait_reg(R_ST, F_DBR, F_DBR);
      chk("slave_rx", rx, exp_q.pop_front());
    end
    nack <= 1'b1;
    apb(1'b1, R_SDA, 8'($random(seed)));
    wait_reg(R_ST, F_NAK, F_NAK);
    chk("nack_status", rd & F_ALL, F_MST | F_NAK);
    chk("irq_nack", {7'h00, irq}, 8'h01);
    stop(F_NAK);
    nack <= 1'b0;
    tx <= 8'($random(seed));
    start(K_ACK);
    apb(1'b1, R_SDA, {SLV, 1'b1});
    wait_reg(R_ST, F_DBR, F_DBR);
    chk("rx_auto", rd & F_ALL, F_MST | F_DBR);
    apb(1'b1, R_C1, K_STA | K_ACK);
    apb(1'b0, R_SDA, 8'h00);
    chk("rs_data", rd, tx);
    apb(1'b0, R_ST, 8'h00);
    chk("rs_dbr", rd & F_DBR, F_DBR);
    apb(1'b1, R_SDA, {SLV, 1'b1});
    wait_reg(R_ST, F_DBR, F_DBR);
    chk("rs_rx", rd & F_ALL, F_MST | F_DBR);
    stop(8'h00);
    start(8'h00);
    apb(1'b1, R_SDA, 8'hFF);
    repeat (12) @(posedge clk);
    frc_sda <= 1'b1;
    wait_reg(R_ST, F_BER, F_BER);
    frc_sda <= 1'b0;
    chk("bus_error", rd & (F_BER | F_MST), F_BER);
    apb(1'b1, R_ST, 8'h00);
    apb(1'b0, R_ST, 8'h00);
    chk("ber_write0", rd & F_BER, F_BER);
    apb(1'b1, R_ST, F_BER);
    apb(1'b1, R_CST, 8'h01);
    repeat (50) @(posedge clk);
    apb(1'b1, R_C2, 8'h08);
    apb(1'b0, R_ST, 8'h00);
    chk("status_disabled", rd, 8'h00);
    apb(1'b1, R_C2, 8'h09);
    apb(1'b0, R_CST, 8'h00);
    chk("cst_reenabled", rd, 8'h00);
    addr_case(1'b0);
    addr_case(1'b1);
    close_out;
  end
endmodule
`default_nettype wire

// *** tb/smbm_engine_checker.sv ***
// Purpose: Concurrent checks on the master engine register port and bus outputs.
// Assumes: Register index sits in paddr[9:2]; every access has one wait state.
// Notes:   Helper flops mirror enable bits from writes.
`default_nettype none
module smbm_engine_checker #(
  parameter int unsigned AW = 12
) (
  input wire logic          i_clock,
  input wire logic          i_rst_n,
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic          i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0]   i_pwdata,
  input wire logic [31:0]   o_prdata,
  input wire logic          o_pready,
  input wire logic          o_pslverr,
  input wire logic          i_scl,
  input wire logic          i_sda,
  input wire logic          o_scl_o,
  input wire logic          o_scl_oe,
  input wire logic          o_sda_o,
  input wire logic          o_sda_oe,
  input wire logic          o_irq
);
  logic [7:0] idx;
  logic       wr_hit;
  logic       unmapped;
  logic       en_q;
  logic       ien_q;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // Decode of the word index and of an accepted write.
  assign idx      = i_paddr[9:2];
  assign wr_hit   = i_psel && i_penable && o_pready && i_pwrite;
  assign unmapped = idx[0] || (idx > smbm_pkg::IDX_ADDR2);
  // Mirror of the enable and interrupt enable bits.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      en_q  <= 1'b0;
      ien_q <= 1'b0;
    end else if (wr_hit && idx == smbm_pkg::IDX_CTL2) begin
      en_q  <= i_pwdata[smbm_pkg::C2_EN];
      ien_q <= ien_q && i_pwdata[smbm_pkg::C2_EN];
    end else if (wr_hit && idx == smbm_pkg::IDX_CTL1) begin
      ien_q <= i_pwdata[smbm_pkg::C1_IRQ];
    end
  end
  AST_PREADY_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("pready wider than one cycle");
  AST_SLVERR_MAP: assert property (o_pready |-> o_pslverr == unmapped)
    else $error("pslverr wrong for index");
  AST_OPEN_DRAIN: assert property (!o_scl_o && !o_sda_o)
    else $error("line output value not low");
  AST_RST_QUIET: assert property (disable iff (1'b0) !i_rst_n |=> !o_pready && !o_irq && !o_scl_oe && !o_sda_oe)
    else $error("outputs active after reset");
  AST_ST_DISABLED: assert property (o_pready && !i_pwrite && idx == smbm_pkg::IDX_ST && !en_q |-> o_prdata == 32'h0)
    else $error("status not zero while disabled");
  AST_IRQ_MASKED: assert property (!ien_q |=> !o_irq)
    else $error("interrupt while masked");
  AST_START_HOLD: assert property ($rose(o_sda_oe) && !o_scl_oe |-> ##[1:300] o_scl_oe)
    else $error("clock not held low after start");
  AST_STOP_IDLE: assert property ($fell(o_sda_oe) && !o_scl_oe && !$past(o_scl_oe) |=> !o_scl_oe [*4])
    else $error("clock pulled right after stop");
endmodule
bind smbm_engine smbm_engine_checker #(.AW(AW)) chk_u (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_scl(i_scl), .i_sda(i_sda), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_irq(o_irq));
`default_nettype wire

// *** tb/smbm_slave_model.sv ***
// Purpose: Behavioural slave device on the two-wire bus.
// Assumes: Open-drain lines with pull-ups are resolved by the bench.
// Notes:   Stretching holds the clock low 200 ns after each falling edge.
`default_nettype none
module smbm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_nack,
  input  wire logic       i_stretch,
  input  wire logic [7:0] i_tx,
  output logic            o_sda_pull,
  output logic            o_scl_pull,
  output logic      [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bitc = 0;
  logic       adr_ph = 1'b0;
  logic       sel = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;
  // Lines start released.
  initial begin
    o_sda_pull = 1'b0;
    o_scl_pull = 1'b0;
    o_rx = 8'h00;
  end
  // A start condition opens an address byte; a stop deselects.
  always @(negedge i_sda iff i_scl) begin
    bitc = 0;
    adr_ph = 1'b1;
    sel = 1'b0;
  end
  always @(posedge i_sda iff i_scl) sel = 1'b0;
  // Bits are taken on the rising clock; a master NACK ends a read.
  always @(posedge i_scl) begin
    if (bitc < 8) sh = {sh[6:0], i_sda};
    if (bitc == 8 && rd && i_sda) sel = 1'b0;
    bitc = bitc + 1;
  end
  // Data changes only while the clock is low, never as a start or stop.
  always @(negedge i_scl) begin
    o_sda_pull = 1'b0;
    if (bitc == 9) bitc = 0;
    if (bitc == 8 && adr_ph) begin
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      adr_ph = 1'b0;
      o_sda_pull = sel;
    end else if (bitc == 8) begin
      o_rx = sh;
      o_sda_pull = sel && !rd && !i_nack;
    end else if (sel && rd) begin
      o_sda_pull = !i_tx[7 - bitc];
    end
    if (i_stretch) begin
      o_scl_pull = 1'b1;
      #200;
      o_scl_pull = 1'b0;
    end
  end
endmodule
`default_nettype wire
